//--- hdl/tlas_pkg.sv
package tlas_pkg;

    // ==========================================================
    // Register pointers
    localparam logic [2:0] PTR_TEMP  = 3'h0;
    localparam logic [2:0] PTR_CFG   = 3'h1;
    localparam logic [2:0] PTR_UPPER = 3'h2;
    localparam logic [2:0] PTR_LOWER = 3'h3;
    localparam logic [2:0] PTR_CSR   = 3'h4;

    // ==========================================================
    // Reset values
    localparam logic [15:0] TEMP_RST  = 16'h7ffc;
    localparam logic [7:0]  CFG_RST   = 8'h40;
    localparam logic [15:0] UPPER_RST = 16'h7fe0;
    localparam logic [15:0] LOWER_RST = 16'h8000;
    localparam logic [7:0]  CSR_RST   = 8'h08;

    // ==========================================================
    // Field positions
    localparam int LIM_MSB          = 15;
    localparam int LIM_LSB          = 5;
    localparam int TEMP_LSB         = 2;
    localparam int CFG_PWR_DOWN     = 7;
    localparam int CFG_RSVD_ONE     = 6;
    localparam int CFG_ALERT_DIS    = 5;
    localparam int CFG_ALERT_POL    = 4;
    localparam int CFG_ALERT_CLR    = 3;
    localparam int CSR_TMO_DIS      = 7;
    localparam int CSR_RES_HI       = 6;
    localparam int CSR_RES_LO       = 5;
    localparam int CSR_ALERT_LVL    = 3;
    localparam int CSR_OVER         = 2;
    localparam int CSR_UNDER        = 1;
    localparam int CSR_DONE         = 0;

    // ==========================================================
    // Host command registers on Wishbone (byte addresses)
    localparam logic [3:0] WB_CMD    = 4'h0;
    localparam logic [3:0] WB_WDATA  = 4'h4;
    localparam logic [3:0] WB_RDATA  = 4'h8;
    localparam logic [3:0] WB_STATUS = 4'hc;
    localparam int CMD_WE_BIT        = 8;
    localparam int STAT_BUSY_BIT     = 0;
    localparam int STAT_DONE_BIT     = 1;

    // ==========================================================
    // Timing
    localparam int CORE_PERIOD_NS = 25;
    localparam int LINK_PERIOD_NS = 200;
    localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);
    localparam logic [1:0] LINK_HALF_LAST = 2'(LINK_HALF_CYC - 1);

endpackage

//--- hdl/tlas_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface tlas_link_if;
    logic        lk_clk;
    logic        lk_req;
    logic        lk_we;
    logic [2:0]  lk_ptr;
    logic [15:0] lk_wdata;
    logic        lk_ack;
    logic [15:0] lk_rdata;

    modport dev (
        input  lk_clk,
        input  lk_req,
        input  lk_we,
        input  lk_ptr,
        input  lk_wdata,
        output lk_ack,
        output lk_rdata
    );

    modport host (
        output lk_clk,
        output lk_req,
        output lk_we,
        output lk_ptr,
        output lk_wdata,
        input  lk_ack,
        input  lk_rdata
    );
endinterface

`default_nettype wire

//--- hdl/tlas_device.sv
// Summary of operation
// - Upper limit at 0x02, reset 0x7fe0
// - Above upper: alert active, over flag set
// - Limit bits 4:0 read zero
// - Lower limit at 0x03, reset 0x8000
// - Below lower: alert inactive, under flag set
// - Control/flags at 0x04, reset 0x08
// - Bit 7 disables bus idle timeouts
// - Bits 6:5 select 11 to 14 bits
// - Control bit 4 reads zero
// - Bit 3 mirrors alert pin level
// - Alert cleared by command, low, sequence
// - Over flag sticky, read clears when safe
// - Under flag sticky, read clears when safe
// - Bit 0 in one-shot mode zero from reset or start until result, else one
// - Host polls done bit after single conversion
// - Continuous mode: done bit always one
// - Host writes zero to status bits
// - Config bit 5 disables alert output
// - Config bit 4 selects alert polarity
// - Config bit 3 clears alert, reads zero
// - Result bits 15:2 stored, bits 15:5 signed, used for compares
`timescale 1ns/1ps
`default_nettype none

module tlas_device (
    // Clock, reset, enable
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESET_I,
    input  wire logic        CLK_EN_I,
    // Link to host
    tlas_link_if.dev         LINK,
    // Converter side
    input  wire logic [15:0] TEMP_RESULT_I,
    input  wire logic        TEMP_VALID_I,
    input  wire logic        CONV_START_I,
    input  wire logic        ONE_SHOT_MODE_I,
    input  wire logic        ALERT_SEQ_DONE_I,
    // Controls and alert
    output logic             ALERT_O,
    output logic             BUS_TIMEOUT_DISABLE_O,
    output logic [1:0]       RESOLUTION_O,
    output logic             POWER_DOWN_O
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [21:0] s1;
        logic [21:0] s2;
        logic        clk_s3;
        logic        link_ack;
        logic [15:0] link_rdata;
        logic [15:0] temp;
        logic [10:0] upper;
        logic [10:0] lower;
        logic [7:4]  cfg;
        logic        tmo_dis;
        logic [1:0]  res;
        logic        alert_act;
        logic        alert_pin;
        logic        over_flag;
        logic        under_flag;
        logic        above;
        logic        below;
        logic        done;
    } tlas_dev_st_t;

    localparam tlas_dev_st_t ST_RST = '{
        s1:         22'h000000,
        s2:         22'h000000,
        clk_s3:     1'b0,
        link_ack:   1'b0,
        link_rdata: 16'h0000,
        temp:       tlas_pkg::TEMP_RST,
        upper:      tlas_pkg::UPPER_RST[15:5],
        lower:      tlas_pkg::LOWER_RST[15:5],
        cfg:        tlas_pkg::CFG_RST[7:4],
        tmo_dis:    tlas_pkg::CSR_RST[7],
        res:        tlas_pkg::CSR_RST[6:5],
        alert_act:  1'b0,
        alert_pin:  tlas_pkg::CSR_RST[3],
        over_flag:  1'b0,
        under_flag: 1'b0,
        above:      1'b0,
        below:      1'b0,
        done:       1'b0
    };

    tlas_dev_st_t q;
    tlas_dev_st_t d;

    // ==========================================================
    // Helpers
    function automatic logic sgt(input logic [10:0] a,
                                 input logic [10:0] b);
        return $signed(a) > $signed(b);
    endfunction

    function automatic logic [15:0] lim_word(input logic [10:0] v);
        return {v, 5'h00};
    endfunction

    // ==========================================================
    // Next state
    logic        lk_clk_s;
    logic        lk_req_s;
    logic        lk_we_s;
    logic [2:0]  lk_ptr_s;
    logic [15:0] lk_wdata_s;
    logic        access;
    logic        csr_read;
    logic        clr_cmd;
    logic        set_over;
    logic        set_under;
    logic [10:0] meas;
    logic        done_rd;

    always_comb begin
        d = q;
        {lk_clk_s, lk_req_s, lk_we_s, lk_ptr_s, lk_wdata_s} = q.s2;
        d.s1 = {LINK.lk_clk, LINK.lk_req, LINK.lk_we, LINK.lk_ptr,
                LINK.lk_wdata};
        d.s2 = q.s1;
        d.clk_s3 = lk_clk_s;
        access = lk_clk_s & ~q.clk_s3 & lk_req_s & ~q.link_ack;
        csr_read = 1'b0;
        clr_cmd = 1'b0;
        done_rd = ONE_SHOT_MODE_I ? q.done : 1'b1;

        // Link access
        if (!lk_req_s) begin
            d.link_ack = 1'b0;
        end
        if (access) begin
            d.link_ack = 1'b1;
            d.link_rdata = 16'h0000;
            case (lk_ptr_s)
                tlas_pkg::PTR_TEMP: begin
                    d.link_rdata = q.temp;
                end
                tlas_pkg::PTR_CFG: begin
                    d.link_rdata = {8'h00, q.cfg, 4'h0};
                    if (lk_we_s) begin
                        d.cfg = lk_wdata_s[7:4];
                        clr_cmd = lk_wdata_s[tlas_pkg::CFG_ALERT_CLR];
                    end
                end
                tlas_pkg::PTR_UPPER: begin
                    d.link_rdata = lim_word(q.upper);
                    if (lk_we_s) begin
                        d.upper = lk_wdata_s[15:5];
                    end
                end
                tlas_pkg::PTR_LOWER: begin
                    d.link_rdata = lim_word(q.lower);
                    if (lk_we_s) begin
                        d.lower = lk_wdata_s[15:5];
                    end
                end
                tlas_pkg::PTR_CSR: begin
                    d.link_rdata = {8'h00, q.tmo_dis, q.res, 1'b0,
                                    q.alert_pin, q.over_flag,
                                    q.under_flag, done_rd};
                    if (lk_we_s) begin
                        d.tmo_dis = lk_wdata_s[tlas_pkg::CSR_TMO_DIS];
                        d.res = lk_wdata_s[6:5];
                    end else begin
                        csr_read = 1'b1;
                    end
                end
                default: begin
                    d.link_rdata = 16'h0000;
                end
            endcase
        end

        // Conversion result and limit compares
        meas = TEMP_RESULT_I[15:5];
        set_over = TEMP_VALID_I & sgt(meas, q.upper);
        set_under = TEMP_VALID_I & sgt(q.lower, meas);
        if (TEMP_VALID_I) begin
            d.temp = {TEMP_RESULT_I[15:2], 2'b00};
            d.above = set_over;
            d.below = set_under;
        end

        // Done flag: set wins over start
        if (CONV_START_I) begin
            d.done = 1'b0;
        end
        if (TEMP_VALID_I) begin
            d.done = 1'b1;
        end

        // Sticky flags, cleared after read data captured
        d.over_flag = (q.over_flag & ~(csr_read & ~q.above))
                      | set_over;
        d.under_flag = (q.under_flag & ~(csr_read & ~q.below))
                       | set_under;

        // Alert state and pin
        if (set_under | clr_cmd | ALERT_SEQ_DONE_I) begin
            d.alert_act = 1'b0;
        end
        if (set_over) begin
            d.alert_act = 1'b1;
        end
        if (d.cfg[tlas_pkg::CFG_ALERT_DIS]) begin
            d.alert_pin = ~d.cfg[tlas_pkg::CFG_ALERT_POL];
        end else begin
            d.alert_pin = d.alert_act ~^ d.cfg[tlas_pkg::CFG_ALERT_POL];
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            q <= ST_RST;
        end else if (CLK_EN_I) begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign LINK.lk_ack = q.link_ack;
    assign LINK.lk_rdata = q.link_rdata;
    assign ALERT_O = q.alert_pin;
    assign BUS_TIMEOUT_DISABLE_O = q.tmo_dis;
    assign RESOLUTION_O = q.res;
    assign POWER_DOWN_O = q.cfg[tlas_pkg::CFG_PWR_DOWN];

endmodule

`default_nettype wire

//--- hdl/tlas_host.sv
`timescale 1ns/1ps
`default_nettype none

module tlas_host (
    // Clock, reset, enable
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESET_I,
    input  wire logic        CLK_EN_I,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O,
    // Link to device
    tlas_link_if.host        LINK
);

    typedef enum logic [1:0] {
        TLAS_IDLE,
        TLAS_ARM,
        TLAS_WAIT_ACK,
        TLAS_WAIT_REL
    } tlas_hst_state_t;

    typedef struct packed {
        logic            wb_ack;
        logic [31:0]     wb_dat;
        logic [1:0]      div;
        logic            lk_clk;
        logic            req;
        logic            we;
        logic [2:0]      ptr;
        logic [15:0]     wdata;
        logic [16:0]     s1;
        logic [16:0]     s2;
        logic [15:0]     rdata;
        logic            done;
        tlas_hst_state_t state;
    } tlas_hst_st_t;

    localparam tlas_hst_st_t ST_RST = '{
        wb_ack: 1'b0, wb_dat: 32'h00000000, div: 2'h0,
        lk_clk: 1'b0, req: 1'b0, we: 1'b0, ptr: 3'h0,
        wdata: 16'h0000, s1: 17'h00000, s2: 17'h00000,
        rdata: 16'h0000, done: 1'b0, state: TLAS_IDLE
    };

    tlas_hst_st_t q;
    tlas_hst_st_t d;

    logic wb_req;
    logic clk_fall;
    logic ack_s;

    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        d.s1 = {LINK.lk_ack, LINK.lk_rdata};
        d.s2 = q.s1;
        ack_s = q.s2[16];
        wb_req = WB_CYC_I & WB_STB_I & ~q.wb_ack;

        // Link clock divider
        clk_fall = 1'b0;
        if (q.div == tlas_pkg::LINK_HALF_LAST) begin
            d.div = 2'h0;
            d.lk_clk = ~q.lk_clk;
            clk_fall = q.lk_clk;
        end else begin
            d.div = q.div + 2'h1;
        end

        // Wishbone slave, answer one cycle after request
        d.wb_ack = wb_req;
        if (wb_req) begin
            d.wb_dat = 32'h00000000;
            case (WB_ADR_I)
                tlas_pkg::WB_CMD: begin
                    d.wb_dat = {23'h000000, q.we, 5'h00, q.ptr};
                    if (WB_WE_I && WB_SEL_I[0] &&
                        q.state == TLAS_IDLE) begin
                        d.ptr = WB_DAT_I[2:0];
                        d.we = WB_SEL_I[1] & WB_DAT_I[tlas_pkg::CMD_WE_BIT];
                        d.done = 1'b0;
                        d.state = TLAS_ARM;
                    end
                end
                tlas_pkg::WB_WDATA: begin
                    d.wb_dat = {16'h0000, q.wdata};
                    if (WB_WE_I && q.state == TLAS_IDLE) begin
                        if (WB_SEL_I[0]) begin
                            d.wdata[7:0] = WB_DAT_I[7:0];
                        end
                        if (WB_SEL_I[1]) begin
                            d.wdata[15:8] = WB_DAT_I[15:8];
                        end
                    end
                end
                tlas_pkg::WB_RDATA: begin
                    d.wb_dat = {16'h0000, q.rdata};
                end
                tlas_pkg::WB_STATUS: begin
                    d.wb_dat = {30'h00000000, q.done,
                                q.state != TLAS_IDLE};
                end
                default: begin
                    d.wb_dat = 32'h00000000;
                end
            endcase
        end

        // Link transaction
        case (q.state)
            TLAS_IDLE: begin
            end
            TLAS_ARM: begin
                if (clk_fall) begin
                    d.req = 1'b1;
                    d.state = TLAS_WAIT_ACK;
                end
            end
            TLAS_WAIT_ACK: begin
                if (ack_s) begin
                    d.rdata = q.s2[15:0];
                    d.req = 1'b0;
                    d.state = TLAS_WAIT_REL;
                end
            end
            TLAS_WAIT_REL: begin
                if (!ack_s) begin
                    d.done = 1'b1;
                    d.state = TLAS_IDLE;
                end
            end
            default: begin
                d.state = TLAS_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            q <= ST_RST;
        end else if (CLK_EN_I) begin
            q <= d;
        end
    end

    assign WB_ACK_O = q.wb_ack;
    assign WB_DAT_O = q.wb_dat;
    assign LINK.lk_clk = q.lk_clk;
    assign LINK.lk_req = q.req;
    assign LINK.lk_we = q.we;
    assign LINK.lk_ptr = q.ptr;
    assign LINK.lk_wdata = q.wdata;

endmodule

`default_nettype wire

//--- testbench/tlas_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module tlas_assertions (
    // Clock and reset
    input wire logic        CORE_CLK_I,
    input wire logic        RESET_I,
    // Link and device pins
    input wire logic        lk_we,
    input wire logic [2:0]  lk_ptr,
    input wire logic [15:0] lk_wdata,
    input wire logic        lk_ack,
    input wire logic [15:0] lk_rdata,
    input wire logic        ALERT_O,
    input wire logic        BUS_TIMEOUT_DISABLE_O,
    input wire logic [1:0]  RESOLUTION_O,
    input wire logic        ONE_SHOT_MODE_I
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);

    // ==========================================================
    // Link transfer steps
    sequence s_rd(p);
        $rose(lk_ack) && !lk_we && lk_ptr == p;
    endsequence
    sequence s_wr_csr;
        $rose(lk_ack) && lk_we && lk_ptr == tlas_pkg::PTR_CSR;
    endsequence

    a_upper_low_zero: assert property (
        s_rd(tlas_pkg::PTR_UPPER) |-> lk_rdata[4:0] == 5'h00)
        else $error("upper limit low bits not zero");
    a_lower_low_zero: assert property (
        s_rd(tlas_pkg::PTR_LOWER) |-> lk_rdata[4:0] == 5'h00)
        else $error("lower limit low bits not zero");
    a_csr_bit_four: assert property (
        s_rd(tlas_pkg::PTR_CSR) |-> !lk_rdata[4])
        else $error("status bit 4 not zero");
    a_cfg_clear_zero: assert property (
        s_rd(tlas_pkg::PTR_CFG) |-> !lk_rdata[3])
        else $error("alert clear bit not zero");
    a_timeout_follows: assert property (
        s_wr_csr |-> ##[0:3] BUS_TIMEOUT_DISABLE_O == lk_wdata[7])
        else $error("timeout disable not written");
    a_res_follows: assert property (
        s_wr_csr |-> ##[0:3] RESOLUTION_O == lk_wdata[6:5])
        else $error("resolution not written");
    a_alert_mirror: assert property (
        s_rd(tlas_pkg::PTR_CSR) ##0 $stable(ALERT_O)
        |-> lk_rdata[3] == ALERT_O)
        else $error("alert status bit differs from pin");
    a_done_continuous: assert property (
        s_rd(tlas_pkg::PTR_CSR) ##0 !ONE_SHOT_MODE_I |-> lk_rdata[0])
        else $error("done bit low in continuous mode");
endmodule

`default_nettype wire

//--- testbench/tb_temp_limit_alert_status.sv
`timescale 1ns/1ps
`default_nettype none

module tb_temp_limit_alert_status;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [15:0] temp = 16'h0;
    logic        tvalid = 1'b0;
    logic        cstart = 1'b0;
    logic        oneshot = 1'b0;
    logic        aseq = 1'b0;
    logic        alert;
    logic        todis;
    logic [1:0]  res;
    logic        pd;
    int          errors = 0;
    int          cmp_count = 0;

    tlas_link_if lnk ();

    tlas_host tlas_host_i (
        .CORE_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(1'b1), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .LINK(lnk.host));

    tlas_device tlas_device_i (
        .CORE_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(1'b1), .LINK(lnk.dev),
        .TEMP_RESULT_I(temp), .TEMP_VALID_I(tvalid), .CONV_START_I(cstart),
        .ONE_SHOT_MODE_I(oneshot), .ALERT_SEQ_DONE_I(aseq), .ALERT_O(alert),
        .BUS_TIMEOUT_DISABLE_O(todis), .RESOLUTION_O(res),
        .POWER_DOWN_O(pd));

    tlas_assertions tlas_assertions_i (
        .CORE_CLK_I(clk), .RESET_I(rst), .lk_we(lnk.lk_we),
        .lk_ptr(lnk.lk_ptr), .lk_wdata(lnk.lk_wdata), .lk_ack(lnk.lk_ack),
        .lk_rdata(lnk.lk_rdata), .ALERT_O(alert),
        .BUS_TIMEOUT_DISABLE_O(todis), .RESOLUTION_O(res),
        .ONE_SHOT_MODE_I(oneshot));

    always #12.5 clk = ~clk;

    // ==========================================================
    // Access tasks
    task automatic test_done;
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("BAD %0t seen %h exp %h", $time, s, e);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
    endtask

    task automatic lk(input logic w, input logic [2:0] p,
                      input logic [15:0] d, output logic [15:0] q);
        logic [31:0] r;
        if (w) wb(1'b1, tlas_pkg::WB_WDATA, {16'h0, d}, r);
        wb(1'b1, tlas_pkg::WB_CMD, {23'h0, w, 5'h0, p}, r);
        do begin
            wb(1'b0, tlas_pkg::WB_STATUS, 32'h0, r);
        end while (r[0] !== 1'b0 || r[1] !== 1'b1);
        wb(1'b0, tlas_pkg::WB_RDATA, 32'h0, r);
        q = r[15:0];
    endtask

    task automatic rd(input logic [2:0] p, input logic [15:0] e);
        logic [15:0] q;
        lk(1'b0, p, 16'h0, q);
        check(q, e);
    endtask

    task automatic wr(input logic [2:0] p, input logic [15:0] d);
        logic [15:0] q;
        lk(1'b1, p, d, q);
    endtask

    task automatic conv(input logic [15:0] t);
        @(posedge clk);
        temp <= t;
        tvalid <= 1'b1;
        @(posedge clk);
        tvalid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic pin(input logic e);
        check({15'h0, alert}, {15'h0, e});
    endtask

    // ==========================================================
    // Tests
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        test_done;
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(tlas_pkg::PTR_UPPER, 16'h7fe0);
        rd(tlas_pkg::PTR_LOWER, 16'h8000);
        rd(tlas_pkg::PTR_CSR, 16'h0009);
        pin(1'b1);
        wr(tlas_pkg::PTR_UPPER, 16'h0c80);
        rd(tlas_pkg::PTR_UPPER, 16'h0c80);
        wr(tlas_pkg::PTR_LOWER, 16'hff20);
        rd(tlas_pkg::PTR_LOWER, 16'hff20);
        for (int r = 0; r < 4; r++) begin
            wr(tlas_pkg::PTR_CSR, {8'h0, r[0], r[1:0], 5'h00});
            rd(tlas_pkg::PTR_CSR, {8'h0, r[0], r[1:0], 5'h09});
            check({14'h0, res}, {14'h0, r[1:0]});
            check({15'h0, todis}, {15'h0, r[0]});
        end
        wr(tlas_pkg::PTR_CSR, 16'h0000);
        conv(16'h0d00);
        pin(1'b0);
        rd(tlas_pkg::PTR_CSR, 16'h0005);
        rd(tlas_pkg::PTR_CSR, 16'h0005);
        conv(16'h0c9c);
        rd(tlas_pkg::PTR_CSR, 16'h0005);
        rd(tlas_pkg::PTR_CSR, 16'h0001);
        wr(tlas_pkg::PTR_CFG, 16'h0048);
        pin(1'b1);
        rd(tlas_pkg::PTR_CFG, 16'h0040);
        check({15'h0, pd}, 16'h0000);
        conv(16'h0d00);
        pin(1'b0);
        conv(16'hff00);
        pin(1'b1);
        rd(tlas_pkg::PTR_CSR, 16'h000f);
        rd(tlas_pkg::PTR_CSR, 16'h000b);
        conv(16'h0000);
        rd(tlas_pkg::PTR_CSR, 16'h000b);
        rd(tlas_pkg::PTR_CSR, 16'h0009);
        conv(16'h0d00);
        pin(1'b0);
        @(posedge clk);
        aseq <= 1'b1;
        @(posedge clk);
        aseq <= 1'b0;
        repeat (3) @(posedge clk);
        pin(1'b1);
        wr(tlas_pkg::PTR_CFG, 16'h0050);
        pin(1'b0);
        conv(16'h0d00);
        pin(1'b1);
        wr(tlas_pkg::PTR_CFG, 16'h0070);
        pin(1'b0);
        rd(tlas_pkg::PTR_CSR, 16'h0005);
        @(posedge clk);
        oneshot <= 1'b1;
        cstart <= 1'b1;
        @(posedge clk);
        cstart <= 1'b0;
        rd(tlas_pkg::PTR_CSR, 16'h0004);
        conv(16'h0d00);
        rd(tlas_pkg::PTR_CSR, 16'h0005);
        test_done;
    end
endmodule

`default_nettype wire
